/* core/pec_pkg.sv */
// Constants shared by the protection element comparator and its timer.
// Assumes a single 20 MHz clock with a synchronous active-high reset.
package pec_pkg;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int VAL_W = 16;
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_GROUP = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_EVENT = 8'h0c;
	localparam logic [7:0] OFS_SCALE_A = 8'h10;
	localparam logic [7:0] OFS_SCALE_B = 8'h14;
	localparam logic [7:0] OFS_MEAS = 8'h18;
	// Setting sets: set n sits at 0x40 + 0x10*n, fields on word index.
	localparam logic [3:0] SET_PAGE0 = 4'h4;
	localparam logic [3:0] SET_PAGE_END = 4'ha;
	localparam logic [1:0] FLD_LEVEL = 2'h0;
	localparam logic [1:0] FLD_ON = 2'h1;
	localparam logic [1:0] FLD_OFF = 2'h2;
	localparam int N_SETS = 7;
	localparam int SET_W = 3;
	localparam logic [2:0] CTRL_SET = 3'h6;
	localparam logic [2:0] GROUP_MIN = 3'h1;
	localparam logic [2:0] GROUP_MAX = 3'h6;
	localparam logic [2:0] GROUP_RST = 3'h1;
	// Control register fields.
	localparam int CTL_FUNC = 0;
	localparam int CTL_CLASS = 1;
	localparam int CTL_TGT = 2;
	localparam int CTL_EVT = 4;
	localparam int CTL_DIG = 5;
	localparam int CTL_BLK = 6;
	localparam int CTL_TRST = 7;
	localparam logic [6:0] CTRL_RST = 7'h00;
	// Status and event fields.
	localparam int STB_RUN = 0;
	localparam int STB_PKP = 1;
	localparam int STB_OPR = 2;
	localparam int STB_TGT = 3;
	localparam int STB_SET = 4;
	localparam int EVB_PKP = 0;
	localparam int EVB_DPO = 1;
	localparam int EVB_OPR = 2;
	// Setting and scale reset values; scale 0x1000 is unity.
	localparam logic [15:0] LEVEL_RST = 16'h1000;
	localparam logic [15:0] DLY_RST = 16'h0000;
	localparam logic [15:0] SCALE_RST = 16'h1000;
	localparam int SCALE_SH = 12;
	// Delay tick of 1 us, least time rounded up to clock cycles.
	localparam int CLK_NS = 50;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int PRE_W = 5;
	typedef enum logic [1:0] {
		PEC_TGT_OFF = 2'b00,
		PEC_TGT_AUTO = 2'b01,
		PEC_TGT_LATCH = 2'b10
	} pec_tgt_t;
	typedef enum logic [1:0] {
		PEC_ST_IDLE = 2'b00,
		PEC_ST_WAIT = 2'b01,
		PEC_ST_OPER = 2'b10,
		PEC_ST_HOLD = 2'b11
	} pec_st_t;
endpackage

/* core/pec_tmr_if.sv */
// Link between the comparator core and its on/off delay timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pec_tmr_if;
	logic run;
	logic pickup;
	logic [15:0] on_dly;
	logic [15:0] off_dly;
	logic operate;
	modport core (output run, output pickup, output on_dly, output off_dly, input operate);
	modport tmr (input run, input pickup, input on_dly, input off_dly, output operate);
endinterface

/* core/pec_timer.sv */
// On-delay and off-delay timer that turns pickup into operate.
// Assumes delays in 1 us ticks and pickup already gated by run.
`timescale 1ns/1ps
module pec_timer (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Link to the comparator core.
	pec_tmr_if.tmr tif
);
	pec_pkg::pec_st_t state_reg, state_next;
	logic [15:0] cnt_reg;
	logic [pec_pkg::PRE_W-1:0] pre_reg;
	logic operate_reg;
	logic tick;

	// A tick marks each elapsed microsecond inside a state.
	assign tick = (pre_reg == pec_pkg::PRE_W'(pec_pkg::TICK_CYC - 1));
	assign tif.operate = operate_reg;

	// Next state; losing run forces idle at once.
	always_comb begin
		state_next = state_reg;
		if (!tif.run) begin
			state_next = pec_pkg::PEC_ST_IDLE;
		end else begin
			case (state_reg)
				pec_pkg::PEC_ST_IDLE: begin
					if (tif.pickup && tif.on_dly == 16'h0000) begin
						state_next = pec_pkg::PEC_ST_OPER;
					end else if (tif.pickup) begin
						state_next = pec_pkg::PEC_ST_WAIT;
					end
				end
				pec_pkg::PEC_ST_WAIT: begin
					if (!tif.pickup) begin
						state_next = pec_pkg::PEC_ST_IDLE;
					end else if (tick && (cnt_reg + 16'h0001) == tif.on_dly) begin
						state_next = pec_pkg::PEC_ST_OPER;
					end
				end
				pec_pkg::PEC_ST_OPER: begin
					if (!tif.pickup && tif.off_dly == 16'h0000) begin
						state_next = pec_pkg::PEC_ST_IDLE;
					end else if (!tif.pickup) begin
						state_next = pec_pkg::PEC_ST_HOLD;
					end
				end
				pec_pkg::PEC_ST_HOLD: begin
					if (tif.pickup) begin
						state_next = pec_pkg::PEC_ST_OPER;
					end else if (tick && (cnt_reg + 16'h0001) == tif.off_dly) begin
						state_next = pec_pkg::PEC_ST_IDLE;
					end
				end
				default: begin
					state_next = pec_pkg::PEC_ST_IDLE;
				end
			endcase
		end
	end

	// State, prescaler and tick counter restart on every state change.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= pec_pkg::PEC_ST_IDLE;
			pre_reg <= '0;
			cnt_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			if (state_next != state_reg) begin
				pre_reg <= '0;
				cnt_reg <= 16'h0000;
			end else if (tick) begin
				pre_reg <= '0;
				cnt_reg <= cnt_reg + 16'h0001;
			end else begin
				pre_reg <= pre_reg + 1'b1;
			end
		end
	end

	// Operate holds through the operate and hold states only.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			operate_reg <= 1'b0;
		end else begin
			operate_reg <= (state_next == pec_pkg::PEC_ST_OPER) ||
				(state_next == pec_pkg::PEC_ST_HOLD);
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence pkp_lost_s;
		state_reg == pec_pkg::PEC_ST_OPER && tif.run && !tif.pickup;
	endsequence

	run_clear_a: assert property (!tif.run |=> !operate_reg)
		else $error("operate still set after run fell");
	no_early_a: assert property ($rose(operate_reg) |-> $past(tif.pickup))
		else $error("operate rose without pickup");
	wait_abort_a: assert property (
		(state_reg == pec_pkg::PEC_ST_WAIT && !tif.pickup) |=>
		(state_reg == pec_pkg::PEC_ST_IDLE && !operate_reg))
		else $error("on-delay not restarted after pickup loss");
	off_hold_a: assert property (
		(pkp_lost_s and tif.off_dly != 16'h0000) |=> operate_reg)
		else $error("operate dropped before off-delay");
endmodule

/* core/pec_comparator.sv */
// Protection element comparator: pickup test, delays, target and events.
// Assumes a classic Wishbone master on clk_i and same-clock measurements.
//
// Notes on behaviour
// - Element inactive unless function enabled; function resets to disabled.
// - Output flag is logic 1 while the input lies in the set range.
// - Pickup flag rises as soon as the measurement exceeds pickup level.
// - Operate rises only after pickup held for the whole programmed time.
// - A programmable on-delay separates pickup from operate.
// - Operate holds for a programmable off-delay after pickup ends, then clears.
// - Every output rests at 0 and leaves it only while the test runs; a latched target and a dropout pulse outlast run.
// - Test runs only while run is 1; run at 0 returns outputs to default; a latched target holds through run at 0 until a reset command.
// - Block is one term of run, so block inhibits the comparator.
// - Grouped element holds six setting sets and uses the active group.
// - Control element uses one fixed set, ignoring the active group.
// - Target disabled gives no target indication on operate.
// - Self-reset target follows operate and clears by itself.
// - Latched target persists after operate until a reset command.
// - Events disabled means no pickup, dropout or operate events.
// - Events enabled gives three distinct events: pickup, dropout, operate.
// - Dropout event comes on the pickup output falling from 1 to 0.
// - Dropout event may occur while still operating with nonzero reset delay.
// - Digital variant compares a logic input; others compare analog values.
// - Currents in per-unit; summed inputs scale to the larger rated input.
// - Voltages in per-unit of nominal primary through the transformer ratio.
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
module pec_comparator (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [pec_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [pec_pkg::DAT_W-1:0] wb_dat_i,
	output logic [pec_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Measurement and supervision inputs.
	input wire logic [pec_pkg::VAL_W-1:0] meas_a_i,
	input wire logic [pec_pkg::VAL_W-1:0] meas_b_i,
	input wire logic digital_i,
	input wire logic block_i,
	// Element outputs.
	output logic pickup_o,
	output logic operate_o,
	output logic target_o,
	output logic pickup_event_o,
	output logic dropout_event_o,
	output logic operate_event_o
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [6:0] ctrl_reg;
	logic [2:0] group_reg;
	logic [2:0] evt_reg;
	logic [15:0] scale_a_reg, scale_b_reg;
	logic [15:0] pu_reg;
	logic [2:0] set_reg;
	logic run_reg, pickup_reg, pkp_prev_reg, tgt_reg;
	logic ack_reg;
	logic [31:0] dat_reg, rd_next;
	logic [1:0] pin_raw, pin_flt;
	logic [15:0] lvl_arr [pec_pkg::N_SETS];
	logic [15:0] on_arr [pec_pkg::N_SETS];
	logic [15:0] off_arr [pec_pkg::N_SETS];
	logic req, wr;
	logic in_sets;
	logic [2:0] adr_set;
	logic [2:0] set_next;
	logic trst;
	logic [32:0] sum_w;
	logic cmp_w;
	pec_pkg::pec_tgt_t tgt_mode;
	pec_tmr_if tif ();

	// ------------------------------------------------------------
	// Wishbone decode
	// ------------------------------------------------------------
	// A request is answered one cycle later; writes land at that edge.
	assign req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr = req && wb_we_i;
	assign in_sets = (wb_adr_i[7:4] >= pec_pkg::SET_PAGE0) &&
		(wb_adr_i[7:4] <= pec_pkg::SET_PAGE_END);
	assign adr_set = 3'(wb_adr_i[7:4] - pec_pkg::SET_PAGE0);
	assign trst = wr && wb_sel_i[0] && wb_adr_i == pec_pkg::OFS_CTRL &&
		wb_dat_i[pec_pkg::CTL_TRST];
	assign tgt_mode = pec_pkg::pec_tgt_t'(ctrl_reg[pec_pkg::CTL_TGT +: 2]);
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// Merges a write into a 16-bit register by byte lane.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = d[7:0];
		end
		if (sel[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	// Acknowledge and registered read data.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			if (req && !wb_we_i) begin
				dat_reg <= rd_next;
			end
		end
	end

	// Read mux; unmapped addresses read as zero.
	always_comb begin
		rd_next = 32'h0000_0000;
		case (wb_adr_i)
			pec_pkg::OFS_CTRL: rd_next[6:0] = ctrl_reg;
			pec_pkg::OFS_GROUP: rd_next[2:0] = group_reg;
			pec_pkg::OFS_STATUS: begin
				rd_next[pec_pkg::STB_RUN] = run_reg;
				rd_next[pec_pkg::STB_PKP] = pickup_reg;
				rd_next[pec_pkg::STB_OPR] = operate_o;
				rd_next[pec_pkg::STB_TGT] = tgt_reg;
				rd_next[pec_pkg::STB_SET +: 3] = set_reg;
			end
			pec_pkg::OFS_EVENT: rd_next[2:0] = evt_reg;
			pec_pkg::OFS_SCALE_A: rd_next[15:0] = scale_a_reg;
			pec_pkg::OFS_SCALE_B: rd_next[15:0] = scale_b_reg;
			pec_pkg::OFS_MEAS: rd_next[15:0] = pu_reg;
			default: begin
				if (in_sets) begin
					case (wb_adr_i[3:2])
						pec_pkg::FLD_LEVEL: rd_next[15:0] = lvl_arr[adr_set];
						pec_pkg::FLD_ON: rd_next[15:0] = on_arr[adr_set];
						pec_pkg::FLD_OFF: rd_next[15:0] = off_arr[adr_set];
						default: rd_next = 32'h0000_0000;
					endcase
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Control, group and scale registers
	// ------------------------------------------------------------
	// Function, class, target mode, events, digital mode and block.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= pec_pkg::CTRL_RST;
			group_reg <= pec_pkg::GROUP_RST;
		end else if (wr && wb_sel_i[0]) begin
			if (wb_adr_i == pec_pkg::OFS_CTRL) begin
				ctrl_reg <= wb_dat_i[6:0];
			end
			if (wb_adr_i == pec_pkg::OFS_GROUP) begin
				group_reg <= wb_dat_i[2:0];
			end
		end
	end

	// Per-input scale factors, unity at 0x1000.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scale_a_reg <= pec_pkg::SCALE_RST;
			scale_b_reg <= pec_pkg::SCALE_RST;
		end else if (wr) begin
			if (wb_adr_i == pec_pkg::OFS_SCALE_A) begin
				scale_a_reg <= merge16(scale_a_reg, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == pec_pkg::OFS_SCALE_B) begin
				scale_b_reg <= merge16(scale_b_reg, wb_dat_i, wb_sel_i);
			end
		end
	end

	// Setting sets 0..5 serve groups 1..6; set 6 is the control set.
	for (genvar g = 0; g < pec_pkg::N_SETS; g++) begin : g_set
		logic [15:0] lvl_reg, on_reg, off_reg;
		logic hit;
		assign hit = wr && in_sets && adr_set == 3'(g);
		assign lvl_arr[g] = lvl_reg;
		assign on_arr[g] = on_reg;
		assign off_arr[g] = off_reg;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				lvl_reg <= pec_pkg::LEVEL_RST;
				on_reg <= pec_pkg::DLY_RST;
				off_reg <= pec_pkg::DLY_RST;
			end else if (hit) begin
				if (wb_adr_i[3:2] == pec_pkg::FLD_LEVEL) begin
					lvl_reg <= merge16(lvl_reg, wb_dat_i, wb_sel_i);
				end
				if (wb_adr_i[3:2] == pec_pkg::FLD_ON) begin
					on_reg <= merge16(on_reg, wb_dat_i, wb_sel_i);
				end
				if (wb_adr_i[3:2] == pec_pkg::FLD_OFF) begin
					off_reg <= merge16(off_reg, wb_dat_i, wb_sel_i);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Digital input and block pin pass three stages; last two must agree.
	assign pin_raw = {block_i, digital_i};
	for (genvar b = 0; b < 2; b++) begin : g_sync
		logic s1_reg, s2_reg, s3_reg, flt_reg;
		assign pin_flt[b] = flt_reg;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				s1_reg <= 1'b0;
				s2_reg <= 1'b0;
				s3_reg <= 1'b0;
				flt_reg <= 1'b0;
			end else begin
				s1_reg <= pin_raw[b];
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
				if (s2_reg == s3_reg) begin
					flt_reg <= s3_reg;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Measurement and comparison
	// ------------------------------------------------------------
	// Software sets each scale so the sum lands in per-unit of the base.
	assign sum_w = 33'(meas_a_i * scale_a_reg) + 33'(meas_b_i * scale_b_reg);

	// Per-unit value, saturated at full scale.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pu_reg <= 16'h0000;
		end else if (|sum_w[32:pec_pkg::SCALE_SH + 16]) begin
			pu_reg <= 16'hffff;
		end else begin
			pu_reg <= sum_w[pec_pkg::SCALE_SH +: 16];
		end
	end

	// Grouped elements follow the active group; control ones use set 6.
	always_comb begin
		if (ctrl_reg[pec_pkg::CTL_CLASS]) begin
			set_next = pec_pkg::CTRL_SET;
		end else if (group_reg < pec_pkg::GROUP_MIN || group_reg > pec_pkg::GROUP_MAX) begin
			set_next = 3'h0;
		end else begin
			set_next = group_reg - 3'h1;
		end
	end

	// Digital mode tests the logic input, else the level is exceeded.
	assign cmp_w = ctrl_reg[pec_pkg::CTL_DIG] ? pin_flt[0] :
		(pu_reg > lvl_arr[set_reg]);

	// Run combines function enable with both block terms.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			set_reg <= 3'h0;
			run_reg <= 1'b0;
			pickup_reg <= 1'b0;
		end else begin
			set_reg <= set_next;
			run_reg <= ctrl_reg[pec_pkg::CTL_FUNC] &&
				!ctrl_reg[pec_pkg::CTL_BLK] && !pin_flt[1];
			pickup_reg <= run_reg && cmp_w;
		end
	end

	assign tif.run = run_reg;
	assign tif.pickup = pickup_reg;
	assign tif.on_dly = on_arr[set_reg];
	assign tif.off_dly = off_arr[set_reg];

	pec_timer u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tif(tif)
	);

	// ------------------------------------------------------------
	// Outputs, events and target
	// ------------------------------------------------------------
	// Edge detection gives one-cycle event pulses when enabled.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pkp_prev_reg <= 1'b0;
			operate_o <= 1'b0;
			pickup_event_o <= 1'b0;
			dropout_event_o <= 1'b0;
			operate_event_o <= 1'b0;
		end else begin
			pkp_prev_reg <= pickup_reg;
			operate_o <= tif.operate;
			pickup_event_o <= ctrl_reg[pec_pkg::CTL_EVT] && pickup_reg && !pkp_prev_reg;
			dropout_event_o <= ctrl_reg[pec_pkg::CTL_EVT] &&
				!pickup_reg && pkp_prev_reg;
			operate_event_o <= ctrl_reg[pec_pkg::CTL_EVT] && tif.operate && !operate_o;
		end
	end
	assign pickup_o = pickup_reg;

	// Sticky event flags, write one to clear; a new event wins.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_reg <= 3'h0;
		end else if (wr && wb_sel_i[0] && wb_adr_i == pec_pkg::OFS_EVENT) begin
			evt_reg <= (evt_reg & ~wb_dat_i[2:0]) |
				{operate_event_o, dropout_event_o, pickup_event_o};
		end else begin
			evt_reg <= evt_reg | {operate_event_o, dropout_event_o, pickup_event_o};
		end
	end

	// Target indication per mode; latched target set wins over reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tgt_reg <= 1'b0;
		end else begin
			case (tgt_mode)
				pec_pkg::PEC_TGT_AUTO: tgt_reg <= tif.operate;
				pec_pkg::PEC_TGT_LATCH: tgt_reg <= tif.operate || (tgt_reg && !trst);
				default: tgt_reg <= 1'b0;
			endcase
		end
	end
	assign target_o = tgt_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence pkp_fall_s;
		pickup_reg ##1 (!pickup_reg && ctrl_reg[pec_pkg::CTL_EVT]);
	endsequence

	func_off_a: assert property (!ctrl_reg[pec_pkg::CTL_FUNC] |=> ##1 !pickup_o)
		else $error("pickup set while function disabled");
	block_inh_a: assert property (pin_flt[1] |=> ##1 !pickup_o)
		else $error("pickup set while blocked");
	evt_off_a: assert property (!ctrl_reg[pec_pkg::CTL_EVT] |=>
		!(pickup_event_o || dropout_event_o || operate_event_o))
		else $error("event emitted while events disabled");
	dropout_evt_a: assert property (pkp_fall_s |=> dropout_event_o)
		else $error("dropout event missing on pickup fall");
	tgt_off_a: assert property (tgt_mode == pec_pkg::PEC_TGT_OFF |=> !target_o)
		else $error("target shown while target disabled");
	tgt_auto_a: assert property (tgt_mode == pec_pkg::PEC_TGT_AUTO |=>
		target_o == operate_o)
		else $error("self-reset target not following operate");
	tgt_latch_a: assert property ((tgt_mode == pec_pkg::PEC_TGT_LATCH && target_o &&
		!trst) |=> target_o)
		else $error("latched target cleared without reset");
	grp_ctrl_a: assert property (ctrl_reg[pec_pkg::CTL_CLASS] |=>
		set_reg == pec_pkg::CTRL_SET)
		else $error("control element not on fixed set");
	grp_sel_a: assert property ((!ctrl_reg[pec_pkg::CTL_CLASS] && group_reg == 3'h2) |=>
		set_reg == 3'h1)
		else $error("grouped element on wrong set");
endmodule

/* tb/pec_meas_src.sv */
// Model of the measurement channels that feed the comparator.
// Assumes the bench commands new values on the shared clock.
`timescale 1ns/1ps
module pec_meas_src (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Commanded values.
	input wire logic [15:0] set_a_i,
	input wire logic [15:0] set_b_i,
	input wire logic set_d_i,
	// Values seen by the comparator.
	output logic [15:0] meas_a_o,
	output logic [15:0] meas_b_o,
	output logic digital_o
);
	// Channels report a new sample one clock after it is commanded.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meas_a_o <= 16'h0000;
			meas_b_o <= 16'h0000;
			digital_o <= 1'b0;
		end else begin
			meas_a_o <= set_a_i;
			meas_b_o <= set_b_i;
			digital_o <= set_d_i;
		end
	end
endmodule

/* tb/tb.sv */
// Self-checking bench for the protection element comparator.
// Assumes the comparator answers Wishbone and the channel model feeds it.
`timescale 1ns/1ps
module tb;
	typedef struct {logic [7:0] ctl; logic [15:0] a; logic d; logic [2:0] hi; logic tl; logic ev;} pec_row_t;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, block_i = 0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic [15:0] sa = 16'h0, sb = 16'h0, meas_a_i, meas_b_i;
	logic sd = 0, digital_i, wb_ack_o, pickup_o, operate_o, target_o, pe, de, oe;
	int n_mismatch = 0, checked = 0, npk = 0, ndp = 0, nop = 0;
	pec_row_t rows[10] = '{
		'{8'h00, 16'h2000, 0, 3'b000, 0, 0},
		'{8'h01, 16'h2000, 0, 3'b110, 0, 0},
		'{8'h01, 16'h1000, 0, 3'b000, 0, 0},
		'{8'h05, 16'h2000, 0, 3'b111, 0, 0},
		'{8'h09, 16'h2000, 0, 3'b111, 1, 0},
		'{8'h0d, 16'h2000, 0, 3'b110, 0, 0},
		'{8'h41, 16'h2000, 0, 3'b000, 0, 0},
		'{8'h11, 16'h2000, 0, 3'b110, 0, 1},
		'{8'h21, 16'h0000, 1, 3'b110, 0, 0},
		'{8'h21, 16'h2000, 0, 3'b000, 0, 0}};
	// ----------------------------------------
	// Clock, instances and event counters
	// ----------------------------------------
	// Clock of 50 ns period.
	always #25 clk_i = ~clk_i;
	pec_comparator u_pec_comparator (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .meas_a_i(meas_a_i),
		.meas_b_i(meas_b_i), .digital_i(digital_i), .block_i(block_i), .pickup_o(pickup_o),
		.operate_o(operate_o), .target_o(target_o), .pickup_event_o(pe),
		.dropout_event_o(de), .operate_event_o(oe));
	pec_meas_src u_pec_meas_src (.clk_i(clk_i), .rst_i(rst_i), .set_a_i(sa), .set_b_i(sb),
		.set_d_i(sd), .meas_a_o(meas_a_i), .meas_b_o(meas_b_i), .digital_o(digital_i));
	// Event pulses last one cycle, so each sampled high counts once.
	always @(posedge clk_i) begin
		if (pe === 1'b1) npk++;
		if (de === 1'b1) ndp++;
		if (oe === 1'b1) nop++;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		chk(i, 2, "ack latency");
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
		wb(1'b0, a, 32'h0);
		chk(q, e, m);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic meas(input logic [15:0] a, input logic [15:0] b, input logic d);
		sa <= a;
		sb <= b;
		sd <= d;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	// Hang guard well beyond the expected eight hundred or so cycles.
	initial begin
		#500000;
		n_mismatch++;
		end_of_test();
	end
	// Reset, table of ordinary cases, then the awkward ones.
	initial begin
		cyc(3);
		rst_i <= 1'b0;
		cyc(1);
		chk({pickup_o, operate_o, target_o}, 0, "reset flags");
		rd(8'h00, 0, "ctrl reset");
		rd(8'h04, 1, "group reset");
		rd(8'h10, 32'h1000, "scale reset");
		rd(8'h40, 32'h1000, "level reset");
		rd(8'hfc, 0, "unmapped");
		foreach (rows[i]) begin
			meas(0, 0, 0);
			cyc(12);
			wr(8'h00, 32'h80);
			cyc(2);
			chk(target_o, 0, "target reset");
			wr(8'h00, {24'h0, rows[i].ctl});
			npk = 0;
			ndp = 0;
			nop = 0;
			meas(rows[i].a, 0, rows[i].d);
			cyc(14);
			chk({pickup_o, operate_o, target_o}, rows[i].hi, "flags");
			meas(0, 0, 0);
			cyc(14);
			chk({pickup_o, operate_o, target_o}, rows[i].tl, "after");
			chk({npk[1:0], ndp[1:0], nop[1:0]}, {3{1'b0, rows[i].ev}}, "events");
		end
		wr(8'h00, 32'h01);
		block_i <= 1'b1;
		meas(16'h2000, 0, 0);
		cyc(14);
		chk(pickup_o, 0, "pin block");
		block_i <= 1'b0;
		cyc(14);
		chk(operate_o, 1, "unblocked");
		block_i <= 1'b1;
		cyc(8);
		chk({pickup_o, operate_o}, 0, "run drop");
		block_i <= 1'b0;
		meas(0, 0, 0);
		cyc(12);
		wr(8'h50, 32'h3000);
		wr(8'h04, 2);
		meas(16'h2000, 0, 0);
		cyc(14);
		chk(pickup_o, 0, "group 2");
		wr(8'h00, 32'h03);
		cyc(14);
		chk(pickup_o, 1, "control set");
		rd(8'h08, 32'h67, "status control set");
		wr(8'h04, 7);
		wr(8'h00, 32'h01);
		cyc(6);
		rd(8'h08, 32'h07, "group fallback");
		wr(8'h04, 1);
		wr(8'h00, 32'h01);
		cyc(14);
		chk(pickup_o, 1, "group 1");
		meas(0, 0, 0);
		cyc(12);
		wr(8'h44, 2);
		meas(16'h2000, 0, 0);
		cyc(25);
		meas(0, 0, 0);
		cyc(6);
		meas(16'h2000, 0, 0);
		cyc(30);
		chk(operate_o, 0, "on delay restart");
		cyc(20);
		chk(operate_o, 1, "on delay end");
		meas(0, 0, 0);
		cyc(8);
		wr(8'h44, 0);
		wr(8'h48, 2);
		wr(8'h0c, 7);
		wr(8'h00, 32'h11);
		npk = 0;
		ndp = 0;
		nop = 0;
		meas(16'h2000, 0, 0);
		cyc(10);
		meas(0, 0, 0);
		cyc(10);
		chk({pickup_o, operate_o}, 2'b01, "off delay hold");
		chk(ndp, 1, "dropout in operate");
		cyc(40);
		chk(operate_o, 0, "off delay end");
		chk({npk[1:0], nop[1:0]}, 4'h5, "event pair");
		rd(8'h0c, 7, "sticky events");
		wr(8'h0c, 7);
		rd(8'h0c, 0, "events cleared");
		wr(8'h14, 32'h2000);
		meas(16'h0100, 16'h0080, 0);
		cyc(4);
		rd(8'h18, 32'h0200, "per unit sum");
		// Reset in mid-run while the element operates.
		meas(16'h2000, 0, 0);
		cyc(8);
		rst_i <= 1'b1;
		cyc(3);
		rst_i <= 1'b0;
		cyc(1);
		chk({pickup_o, operate_o, target_o}, 0, "mid-run reset flags");
		rd(8'h00, 0, "ctrl after reset");
		rd(8'h14, 32'h1000, "scale after reset");
		end_of_test();
	end
endmodule
